// ==== common/drf_pkg.sv ====
// shared constants, types and helpers for the dma request front end
package drf_pkg;
  localparam int NUM_CH = 16;
  localparam int EXT_N = 2;
  localparam int PERIPH_N = 38;
  // external request minimum high and low time, in memory clocks
  localparam logic [2:0] EXT_MIN_CYC = 3'h4;
  // values after reset: every channel stopped, every requester free to send
  localparam logic [15:0] STOP_RST = 16'hffff;
  localparam logic [1:0] ACK_RST = 2'h3;
  // channel word indices for the software load port
  localparam logic [2:0] W_DESC = 3'h0;
  localparam logic [2:0] W_SRC = 3'h1;
  localparam logic [2:0] W_TGT = 3'h2;
  localparam logic [2:0] W_CMD = 3'h3;
  localparam logic [2:0] W_CTRL = 3'h4;
  // control and status word bit positions
  localparam int C_RUN = 0;
  localparam int C_DIRECT = 1;
  localparam int C_ENDEN = 2;
  localparam int C_STARTEN = 3;
  localparam int C_STOPEN = 4;
  localparam int C_ERR = 8;
  localparam int C_ENDF = 9;
  localparam int C_STARTF = 10;
  localparam int C_STOPPED = 11;
  localparam int C_PEND = 12;
  // command word fields
  localparam int CMD_LEN_LSB = 0;
  localparam int CMD_LEN_W = 13;
  localparam int CMD_BURST_LSB = 13;
  localparam int CMD_WID_LSB = 15;
  localparam int CMD_SEL_LSB = 17;
  localparam int CMD_FLOW = 23;
  localparam logic [5:0] SEL_EXT0 = 6'h26;
  localparam logic [5:0] SEL_EXT1 = 6'h27;
  // descriptor next-address word: stop flag and alignment
  localparam int DESC_STOP = 0;
  localparam logic [31:0] DESC_ALIGN = 32'hfffffff0;
  localparam logic [31:0] WORD_STEP = 32'h00000004;
  // interrupt controller bit carrying the dma interrupt
  localparam int INTC_DMA_BIT = 25;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FETCH = 3'h1,
    S_READ = 3'h3,
    S_WRITE = 3'h2,
    S_NEXT = 3'h6
  } drf_state_e;

  // bytes per burst from its two-bit code
  function automatic logic [5:0] burstBytes(input logic [1:0] code);
    case (code)
      2'h0: burstBytes = 6'h08;
      2'h1: burstBytes = 6'h10;
      default: burstBytes = 6'h20;
    endcase
  endfunction

  // bytes per unit from the port width code
  function automatic logic [5:0] widthBytes(input logic [1:0] code);
    case (code)
      2'h0: widthBytes = 6'h01;
      2'h1: widthBytes = 6'h02;
      default: widthBytes = 6'h04;
    endcase
  endfunction
endpackage

// ==== common/drf_if.sv ====
// link between the dma front end and its requesters and interrupt controller
`timescale 1ns/1ps
interface drf_if;
  logic [1:0] extXferRequest;
  logic [37:0] periphXferRequest;
  logic xferIrq;
  logic burstStart;
  logic [3:0] burstChan;
  logic [1:0] extAck;

  modport dev (
    input extXferRequest,
    input periphXferRequest,
    output xferIrq,
    output burstStart,
    output burstChan,
    output extAck
  );
  modport far (
    output extXferRequest,
    output periphXferRequest,
    input xferIrq,
    input burstStart,
    input burstChan,
    input extAck
  );
endinterface

// ==== verilog/drf_xfer_controller.sv ====
// dma request front end: request capture, channel service, interrupt flags
`timescale 1ns/1ps
// Summary of operation
// - sixteen channels; each request makes bus cycles
// - data passes through holding register to target
// - four 32-bit registers configure each channel
// - serve in bursts, move port-width units
// - software matches burst to peripheral threshold
// - rearbitrate after burst by activity, request, priority; code picks round robin after last served, no priority
// - registers loaded directly or by descriptor fetch
// - software keeps buffers non-cacheable
// - peripheral requests only for whole blocks
// - external requests taken on rising edge
// - requester holds high four, low four
// - requester waits for transfer start before next
// - internal requests are active-high levels
// - internal levels not sampled during transfer
// - per-channel request pending flag readable
// - latched external request survives channel stop
// - sixteen channel interrupts readable together
// - end, start, stop causes individually enabled
// - active-high interrupt when any enabled active
// - interrupt controller pends bit 25, mask gates
// - per-channel load mode, change only when stopped
// - error stops channel until cleared and rerun
module drf_xfer_controller (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to requesters
  drf_if.dev link,
  // software load and readback port
  input wire logic swWr,
  input wire logic [3:0] swChan,
  input wire logic [2:0] swWord,
  input wire logic [31:0] swData,
  input wire logic [3:0] swRdChan,
  input wire logic [2:0] swRdWord,
  output logic [31:0] swRdData,
  output logic [15:0] channelInterruptStatus,
  // memory bus
  output logic memValid,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic memReady,
  input wire logic memErr,
  input wire logic [31:0] memRdata
);
  typedef struct packed {
    drf_pkg::drf_state_e st;
    logic [15:0][3:0][31:0] regs;
    logic [15:0] run, direct, endEn, startEn, stopEn;
    logic [15:0] errF, endF, startF, stopF, pend, needFetch;
    logic [1:0] extS1, extS2, extS3, extLat;
    logic [37:0] perS;
    logic [3:0] cur, rr;
    logic [1:0] fetchIdx;
    logic [5:0] burstLeft;
    logic [31:0] hold, rdData;
    logic memValid, memWrite;
    logic [31:0] memAddr, memWdata;
    logic [15:0] chIrq;
    logic irq, burstStart;
    logic [3:0] burstChan;
    logic [1:0] extAck;
  } drf_dev_s;

  drf_dev_s q, d;

  // pending state of a channel's selected source
  function automatic logic srcPend(input logic [5:0] sel, input logic [37:0] per,
                                   input logic [1:0] ext);
    if (sel == drf_pkg::SEL_EXT0) srcPend = ext[0];
    else if (sel == drf_pkg::SEL_EXT1) srcPend = ext[1];
    else if (sel < drf_pkg::SEL_EXT0) srcPend = per[sel];
    else srcPend = 1'b0;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic [15:0] elig;
    logic found;
    logic [3:0] pick, idx;
    logic [31:0] cmd;
    logic [5:0] wb, sel;
    logic [12:0] len;
    logic [31:0] cw;
    d = q;
    elig = '0;
    found = 1'b0;
    pick = '0;
    idx = '0;
    {cmd, wb, sel, len, cw} = '0;
    d.burstStart = 1'b0;
    d.extAck = 2'h0;
    // two-flop synchroniser then edge detect on the second stage
    d.extS1 = link.extXferRequest;
    d.extS2 = q.extS1;
    d.extS3 = q.extS2;
    d.extLat = q.extLat | (q.extS2 & ~q.extS3);
    // levels only refreshed while no transfer is in flight
    if (q.st == drf_pkg::S_IDLE) begin
      d.perS = link.periphXferRequest;
    end
    // software loads; run needs a cleared error, mode needs a stopped channel
    if (swWr) begin
      if (swWord == drf_pkg::W_CTRL) begin
        if (swData[drf_pkg::C_ERR]) d.errF[swChan] = 1'b0;
        if (swData[drf_pkg::C_ENDF]) d.endF[swChan] = 1'b0;
        if (swData[drf_pkg::C_STARTF]) d.startF[swChan] = 1'b0;
        d.endEn[swChan] = swData[drf_pkg::C_ENDEN];
        d.startEn[swChan] = swData[drf_pkg::C_STARTEN];
        d.stopEn[swChan] = swData[drf_pkg::C_STOPEN];
        if (!q.run[swChan]) begin
          d.direct[swChan] = swData[drf_pkg::C_DIRECT];
        end
        if (swData[drf_pkg::C_RUN] && !q.run[swChan] && !d.errF[swChan]) begin
          d.run[swChan] = 1'b1;
          d.stopF[swChan] = 1'b0;
          d.needFetch[swChan] = !d.direct[swChan];
        end else if (!swData[drf_pkg::C_RUN] && q.run[swChan]) begin
          // latched external edge is left alone on stop
          d.run[swChan] = 1'b0;
          d.stopF[swChan] = 1'b1;
        end
      end else begin
        d.regs[swChan][swWord[1:0]] = swData;
      end
    end
    // eligibility and pending flags per channel
    for (int i = 0; i < drf_pkg::NUM_CH; i++) begin
      cw = q.regs[i][drf_pkg::W_CMD];
      sel = cw[drf_pkg::CMD_SEL_LSB +: 6];
      d.pend[i] = srcPend(sel, q.perS, q.extLat);
      elig[i] = q.run[i] && (q.needFetch[i] || !cw[drf_pkg::CMD_FLOW] || q.pend[i]);
    end
    // round robin from the channel after the last served
    for (int i = 1; i <= drf_pkg::NUM_CH; i++) begin
      idx = q.rr + i[3:0];
      if (!found && elig[idx]) begin
        found = 1'b1;
        pick = idx;
      end
    end
    cmd = q.regs[q.cur][drf_pkg::W_CMD];
    len = cmd[drf_pkg::CMD_LEN_LSB +: drf_pkg::CMD_LEN_W];
    wb = drf_pkg::widthBytes(cmd[drf_pkg::CMD_WID_LSB +: 2]);
    case (q.st)
      drf_pkg::S_IDLE: begin
        if (found) begin
          d.cur = pick;
          d.rr = pick;
          d.memValid = 1'b1;
          d.memWrite = 1'b0;
          if (q.needFetch[pick]) begin
            d.fetchIdx = 2'h0;
            d.memAddr = q.regs[pick][drf_pkg::W_DESC] & drf_pkg::DESC_ALIGN;
            d.st = drf_pkg::S_FETCH;
          end else begin
            cw = q.regs[pick][drf_pkg::W_CMD];
            sel = cw[drf_pkg::CMD_SEL_LSB +: 6];
            d.burstLeft = drf_pkg::burstBytes(cw[drf_pkg::CMD_BURST_LSB +: 2]);
            d.burstStart = 1'b1;
            d.burstChan = pick;
            // the latch is consumed when its service begins
            if (cw[drf_pkg::CMD_FLOW] && sel == drf_pkg::SEL_EXT0) begin
              d.extLat[0] = 1'b0;
              d.extAck[0] = 1'b1;
            end
            if (cw[drf_pkg::CMD_FLOW] && sel == drf_pkg::SEL_EXT1) begin
              d.extLat[1] = 1'b0;
              d.extAck[1] = 1'b1;
            end
            d.memAddr = q.regs[pick][drf_pkg::W_SRC];
            d.st = drf_pkg::S_READ;
          end
        end
      end
      drf_pkg::S_FETCH: begin
        if (memReady) begin
          d.regs[q.cur][q.fetchIdx] = memRdata;
          d.fetchIdx = q.fetchIdx + 2'h1;
          d.memAddr = q.memAddr + drf_pkg::WORD_STEP;
          if (q.fetchIdx == 2'h3) begin
            d.memValid = 1'b0;
            d.needFetch[q.cur] = 1'b0;
            d.startF[q.cur] = 1'b1;
            d.st = drf_pkg::S_IDLE;
          end
        end
      end
      drf_pkg::S_READ: begin
        if (memReady) begin
          // flow-through: word held here, then written out
          d.hold = memRdata;
          d.memWdata = memRdata;
          d.memWrite = 1'b1;
          d.memAddr = q.regs[q.cur][drf_pkg::W_TGT];
          d.st = drf_pkg::S_WRITE;
        end
      end
      drf_pkg::S_WRITE: begin
        if (memReady) begin
          d.regs[q.cur][drf_pkg::W_SRC] = q.regs[q.cur][drf_pkg::W_SRC] + {26'h0, wb};
          d.regs[q.cur][drf_pkg::W_TGT] = q.regs[q.cur][drf_pkg::W_TGT] + {26'h0, wb};
          d.regs[q.cur][drf_pkg::W_CMD][drf_pkg::CMD_LEN_LSB +: drf_pkg::CMD_LEN_W] =
            (len > {7'h0, wb}) ? len - {7'h0, wb} : 13'h0;
          d.burstLeft = (q.burstLeft > wb) ? q.burstLeft - wb : 6'h0;
          d.memWrite = 1'b0;
          if (len <= {7'h0, wb} || q.burstLeft <= wb) begin
            d.memValid = 1'b0;
            d.st = drf_pkg::S_NEXT;
          end else begin
            d.memAddr = q.regs[q.cur][drf_pkg::W_SRC] + {26'h0, wb};
            d.st = drf_pkg::S_READ;
          end
        end
      end
      drf_pkg::S_NEXT: begin
        if (len == 13'h0) begin
          d.endF[q.cur] = 1'b1;
          if (q.direct[q.cur] || q.regs[q.cur][drf_pkg::W_DESC][drf_pkg::DESC_STOP]) begin
            d.run[q.cur] = 1'b0;
            d.stopF[q.cur] = 1'b1;
          end else begin
            d.needFetch[q.cur] = 1'b1;
          end
        end
        d.st = drf_pkg::S_IDLE;
      end
      default: d.st = drf_pkg::S_IDLE;
    endcase
    // a bus error aborts and stops the channel
    if (memErr && q.memValid && q.st != drf_pkg::S_IDLE) begin
      d.errF[q.cur] = 1'b1;
      d.run[q.cur] = 1'b0;
      d.stopF[q.cur] = 1'b1;
      d.memValid = 1'b0;
      d.memWrite = 1'b0;
      d.st = drf_pkg::S_IDLE;
    end
    // enabled causes per channel, then one level toward the controller
    d.chIrq = (q.endF & q.endEn) | (q.startF & q.startEn) | (q.stopF & q.stopEn);
    d.irq = |q.chIrq;
    // readback
    if (swRdWord == drf_pkg::W_CTRL) begin
      d.rdData = '0;
      d.rdData[drf_pkg::C_RUN] = q.run[swRdChan];
      d.rdData[drf_pkg::C_DIRECT] = q.direct[swRdChan];
      d.rdData[drf_pkg::C_ENDEN] = q.endEn[swRdChan];
      d.rdData[drf_pkg::C_STARTEN] = q.startEn[swRdChan];
      d.rdData[drf_pkg::C_STOPEN] = q.stopEn[swRdChan];
      d.rdData[drf_pkg::C_ERR] = q.errF[swRdChan];
      d.rdData[drf_pkg::C_ENDF] = q.endF[swRdChan];
      d.rdData[drf_pkg::C_STARTF] = q.startF[swRdChan];
      d.rdData[drf_pkg::C_STOPPED] = q.stopF[swRdChan];
      d.rdData[drf_pkg::C_PEND] = q.pend[swRdChan];
    end else if (swRdWord[2]) begin
      d.rdData = '0;
    end else begin
      d.rdData = q.regs[swRdChan][swRdWord[1:0]];
    end
  end

  // state register; channels come up stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.stopF <= drf_pkg::STOP_RST;
    end else begin
      q <= d;
    end
  end

  assign swRdData = q.rdData;
  assign channelInterruptStatus = q.chIrq;
  assign memValid = q.memValid;
  assign memWrite = q.memWrite;
  assign memAddr = q.memAddr;
  assign memWdata = q.memWdata;
  assign link.xferIrq = q.irq;
  assign link.burstStart = q.burstStart;
  assign link.burstChan = q.burstChan;
  assign link.extAck = q.extAck;
endmodule

// ==== verilog/drf_req_agent.sv ====
// requester side: external request pacing, peripheral levels, interrupt gating
`timescale 1ns/1ps
module drf_req_agent (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to the dma front end
  drf_if.far link,
  // user requests
  input wire logic [1:0] sendExt,
  input wire logic [37:0] periphWant,
  output logic [1:0] extBusy,
  // interrupt controller view
  input wire logic [31:0] intcMaskReg,
  output logic [31:0] intcPendingReg,
  output logic cpuIrq
);
  typedef struct packed {
    logic [1:0] line, lowPhase, ackSeen;
    logic [1:0][2:0] cnt;
    logic [37:0] per;
    logic [31:0] pending;
    logic cpuIrq;
  } drf_far_s;

  drf_far_s q, d;

  // pacing per external line: high four, low four, wait for service start
  always_comb begin
    d = q;
    d.per = periphWant;
    for (int i = 0; i < drf_pkg::EXT_N; i++) begin
      if (link.extAck[i]) d.ackSeen[i] = 1'b1;
      if (q.line[i]) begin
        d.cnt[i] = q.cnt[i] + 3'h1;
        if (q.cnt[i] + 3'h1 >= drf_pkg::EXT_MIN_CYC) begin
          d.line[i] = 1'b0;
          d.lowPhase[i] = 1'b1;
          d.cnt[i] = 3'h0;
        end
      end else if (q.lowPhase[i]) begin
        d.cnt[i] = q.cnt[i] + 3'h1;
        if (q.cnt[i] + 3'h1 >= drf_pkg::EXT_MIN_CYC) begin
          d.lowPhase[i] = 1'b0;
          d.cnt[i] = 3'h0;
        end
      end else if (sendExt[i] && d.ackSeen[i]) begin
        d.line[i] = 1'b1;
        d.ackSeen[i] = 1'b0;
        d.cnt[i] = 3'h0;
      end
    end
    // pending follows the dma level; mask gates it to the processor
    d.pending = '0;
    d.pending[drf_pkg::INTC_DMA_BIT] = link.xferIrq;
    d.cpuIrq = q.pending[drf_pkg::INTC_DMA_BIT] & intcMaskReg[drf_pkg::INTC_DMA_BIT];
  end

  // state register; lines may fire once after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ackSeen <= drf_pkg::ACK_RST;
    end else begin
      q <= d;
    end
  end

  assign link.extXferRequest = q.line;
  assign link.periphXferRequest = q.per;
  assign extBusy = q.line | q.lowPhase | ~q.ackSeen;
  assign intcPendingReg = q.pending;
  assign cpuIrq = q.cpuIrq;
endmodule

// ==== sim/drf_props.sv ====
// assertions on the request link between the front end and its requesters
`timescale 1ns/1ps
module drf_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic [1:0] extXferRequest,
  input wire logic [37:0] periphXferRequest,
  input wire logic xferIrq,
  input wire logic burstStart,
  input wire logic [3:0] burstChan,
  input wire logic [1:0] extAck
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // one level held for four memory clocks
  sequence hold4(s, v);
    (s == v) [*4];
  endsequence
  // line raised, held, then dropped
  sequence pulse4(s);
    hold4(s, 1'b1) ##1 !s;
  endsequence
  ext0_high_hold_a: assert property (
    $rose(extXferRequest[0]) |-> pulse4(extXferRequest[0])) else $error("ext0 high time");
  ext1_high_hold_a: assert property (
    $rose(extXferRequest[1]) |-> pulse4(extXferRequest[1])) else $error("ext1 high time");
  ext0_low_hold_a: assert property (
    $fell(extXferRequest[0]) |-> hold4(extXferRequest[0], 1'b0)) else $error("ext0 low time");
  ext1_low_hold_a: assert property (
    $fell(extXferRequest[1]) |-> hold4(extXferRequest[1], 1'b0)) else $error("ext1 low time");
  // synchroniser delay means no service in the first three cycles
  ack0_after_sync_a: assert property (
    $rose(extXferRequest[0]) |-> !extAck[0] [*3]) else $error("ext0 served too early");
  ack1_after_sync_a: assert property (
    $rose(extXferRequest[1]) |-> !extAck[1] [*3]) else $error("ext1 served too early");
  ack_single_pulse_a: assert property (
    |extAck |=> extAck == 2'h0) else $error("ack longer than one cycle");
  burst_single_pulse_a: assert property (
    burstStart |=> !burstStart) else $error("burst start repeated");
endmodule

// ==== sim/dma_request_front_end_tb_top.sv ====
// self-checking bench joining controller and requester agent
`timescale 1ns/1ps
module dma_request_front_end_tb_top;
  logic clk, rst_n, swWr, memValid, memWrite, memReady, memErr, cpuIrq;
  logic [3:0] swChan, swRdChan;
  logic [2:0] swWord, swRdWord;
  logic [31:0] swData, swRdData, memAddr, memWdata, memRdata, intcMaskReg, intcPendingReg, errAddr;
  logic [15:0] channelInterruptStatus;
  logic [31:0] reqA, reqD;
  logic reqV, reqW;
  logic [1:0] sendExt, extBusy;
  logic [37:0] periphWant;
  logic [31:0] mem [logic [31:0]];
  int bc [16];
  int ac [2];
  int errors, comparisons;
  drf_if link ();
  drf_xfer_controller drf_xfer_controller_i (.clk(clk), .rst_n(rst_n), .link(link.dev),
    .swWr(swWr), .swChan(swChan), .swWord(swWord), .swData(swData), .swRdChan(swRdChan),
    .swRdWord(swRdWord), .swRdData(swRdData), .channelInterruptStatus(channelInterruptStatus),
    .memValid(memValid), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
    .memReady(memReady), .memErr(memErr), .memRdata(memRdata));
  drf_req_agent drf_req_agent_i (.clk(clk), .rst_n(rst_n), .link(link.far), .sendExt(sendExt),
    .periphWant(periphWant), .extBusy(extBusy), .intcMaskReg(intcMaskReg),
    .intcPendingReg(intcPendingReg), .cpuIrq(cpuIrq));
  drf_props drf_props_i (.clk(clk), .rst_n(rst_n), .extXferRequest(link.extXferRequest),
    .periphXferRequest(link.periphXferRequest), .xferIrq(link.xferIrq),
    .burstStart(link.burstStart), .burstChan(link.burstChan), .extAck(link.extAck));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // plain memory, no cache in front; answers after a random wait, one address can fault
  // writes commit half a cycle after the edge that took them, from the request held
  // since the edge before, so the design's own update at that edge cannot race them
  always @(negedge clk) begin
    if (reqV && memReady && reqW)
      mem[reqA] = reqD;
    if (link.burstStart)
      bc[link.burstChan]++;
    for (int i = 0; i < 2; i++)
      if (link.extAck[i])
        ac[i]++;
    {reqV, reqW, reqA, reqD} = {memValid, memWrite, memAddr, memWdata};
    memReady = memValid && ($urandom % 3 != 0);
    memErr = memReady && (memAddr === errAddr);
    memRdata = mem.exists(memAddr) ? mem[memAddr] : ~memAddr;
  end
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // an idle cycle between strobes keeps each write distinct
  task automatic wr(input logic [3:0] ch, input logic [2:0] w, input logic [31:0] d);
    @(negedge clk);
    swWr = 1'b1;
    swChan = ch;
    swWord = w;
    swData = d;
    @(negedge clk);
    swWr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] ch, input logic [2:0] w, output logic [31:0] d);
    @(negedge clk);
    swRdChan = ch;
    swRdWord = w;
    @(negedge clk);
    d = swRdData;
  endtask
  task automatic waitFlag(input logic [3:0] ch, input int pos);
    logic [31:0] d;
    for (int n = 0; n <= 3000; n++) begin
      rd(ch, drf_pkg::W_CTRL, d);
      if (d[pos] === 1'b1)
        break;
      if (n == 3000) begin
        errors++;
        complete_run();
      end
    end
  endtask
  function automatic logic [31:0] cmdw(input int len, input logic [1:0] b, input logic [1:0] wd,
    input logic [5:0] sel, input logic flow);
    cmdw = {8'h00, flow, sel, wd, b, len[12:0]};
  endfunction
  function automatic int nBursts(input int len, input logic [1:0] b);
    int bb;
    bb = (b == 2'h0) ? 8 : (b == 2'h1) ? 16 : 32;
    nBursts = (len + bb - 1) / bb;
  endfunction
  // load a channel directly or through a descriptor with its stop bit set
  task automatic startCh(input logic [3:0] ch, input logic dir, input logic [31:0] src,
    input logic [31:0] cmd, input logic [31:0] ctl);
    if (dir) begin
      wr(ch, drf_pkg::W_SRC, src);
      wr(ch, drf_pkg::W_TGT, src + 32'h1000);
      wr(ch, drf_pkg::W_CMD, cmd);
    end else begin
      mem[32'h800] = 32'h1;
      mem[32'h804] = src;
      mem[32'h808] = src + 32'h1000;
      mem[32'h80c] = cmd;
      wr(ch, drf_pkg::W_DESC, 32'h800);
    end
    wr(ch, drf_pkg::W_CTRL, ctl | {30'h0, dir, 1'b0});
  endtask
  initial begin
    logic [31:0] d, src;
    logic [3:0] ch;
    logic [1:0] b, wd;
    logic en;
    int len, p;
    {swWr, swChan, swWord, swData, swRdChan, swRdWord, sendExt, periphWant} = '0;
    {intcMaskReg, memReady, memErr, memRdata, rst_n} = '0;
    errAddr = 32'hffffffff;
    void'($urandom(32'h15e5));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd(4'h0, drf_pkg::W_CTRL, d);
    chk(d, 32'h800, "ctrl after reset");
    for (int w = 1; w < 4; w++) begin
      src = $urandom;
      wr(4'h9, w[2:0], src);
      rd(4'h9, w[2:0], d);
      chk(d, src, "word readback");
    end
    // copies with random length, burst and channel; enable and mask bit 25 set from the iteration count
    for (int it = 0; it < 6; it++) begin
      len = (it == 0) ? 4 : 4 * (1 + $urandom % 16);
      b = $urandom % 3;
      wd = $urandom % 3;
      ch = $urandom % 16;
      en = it[0];
      intcMaskReg = $urandom;
      intcMaskReg[25] = it[1];
      src = 32'h100 * (it + 1);
      for (int k = 0; k < len / 4; k++)
        mem[src + 4 * k] = $urandom;
      bc[ch] = 0;
      startCh(ch, it < 4, src, cmdw(len, b, wd, 6'h0, 1'b0), en ? 32'hd : 32'h1);
      waitFlag(ch, drf_pkg::C_ENDF);
      repeat (4) @(negedge clk);
      for (int k = 0; k < len / 4; k++)
        chk(mem[src + 32'h1000 + 4 * k], mem[src + 4 * k], "copied word");
      chk(bc[ch], nBursts(len, b), "burst count");
      chk(channelInterruptStatus[ch], en, "channel irq");
      chk(link.xferIrq, en, "irq line");
      chk(cpuIrq, en & it[1], "cpu irq");
      chk(intcPendingReg, {6'h0, en, 25'h0}, "pending bit");
      rd(ch, drf_pkg::W_CTRL, d);
      if (it >= 4)
        chk(d[drf_pkg::C_STARTF], 1'b1, "start flag");
      chk(d[drf_pkg::C_STOPPED], 1'b1, "stopped at end");
      wr(ch, drf_pkg::W_CTRL, 32'h600);
      repeat (4) @(negedge clk);
      chk(link.xferIrq, 1'b0, "irq cleared");
    end
    // edge arrives while channel stopped, then the channel runs
    for (int ln = 0; ln < 2; ln++) begin
      ch = 4'h5 + ln[3:0];
      bc[ch] = 0;
      ac[ln] = 0;
      startCh(ch, 1'b1, 32'h900,
        cmdw(8, 2'h0, 2'h2, drf_pkg::SEL_EXT0 | {5'h0, ln[0]}, 1'b1), 32'h0);
      @(negedge clk);
      sendExt[ln] = 1'b1;
      @(negedge clk);
      sendExt[ln] = 1'b0;
      repeat (10) @(negedge clk);
      rd(ch, drf_pkg::W_CTRL, d);
      chk(d[drf_pkg::C_PEND], 1'b1, "pending while stopped");
      chk(bc[ch], 0, "no service while stopped");
      chk(extBusy[ln], 1'b1, "busy until served");
      // run with the direct bit kept, else the channel would fetch a descriptor
      wr(ch, drf_pkg::W_CTRL, 32'h3);
      waitFlag(ch, drf_pkg::C_ENDF);
      chk(ac[ln], 1, "one ack per edge");
      rd(ch, drf_pkg::W_CTRL, d);
      chk(d[drf_pkg::C_PEND], 1'b0, "pending served");
      chk(extBusy[ln], 1'b0, "free after service");
      wr(ch, drf_pkg::W_CTRL, 32'h200);
    end
    // peripheral level gates service
    p = $urandom % 38;
    bc[7] = 0;
    startCh(4'h7, 1'b1, 32'ha00, cmdw(16, 2'h0, 2'h2, p[5:0], 1'b1), 32'h1);
    repeat (20) @(negedge clk);
    chk(bc[7], 0, "no level no service");
    periphWant[p] = 1'b1;
    waitFlag(4'h7, drf_pkg::C_ENDF);
    periphWant = '0;
    chk(bc[7], 2, "level bursts");
    // bus fault stops the channel; rerun refused while error stands
    errAddr = 32'hb00;
    startCh(4'h2, 1'b1, 32'hb00, cmdw(8, 2'h0, 2'h2, 6'h0, 1'b0), 32'h1);
    waitFlag(4'h2, drf_pkg::C_ERR);
    p = bc[2];
    wr(4'h2, drf_pkg::W_CTRL, 32'h3);
    repeat (4) @(negedge clk);
    rd(4'h2, drf_pkg::W_CTRL, d);
    chk(d[drf_pkg::C_STOPPED], 1'b1, "stays stopped");
    chk(bc[2], p, "no rerun while error");
    // clearing the error in the same write lets the run bit take
    wr(4'h2, drf_pkg::W_CTRL, 32'h103);
    repeat (10) @(negedge clk);
    chk(bc[2], p + 1, "rerun after clear");
    complete_run();
  end
endmodule
